// *** logic/fsl_defines.svh ***
// Address, field and timing constants of the flash security interlock.
`ifndef FSL_DEFINES_SVH
`define FSL_DEFINES_SVH

// ==========================================================================
// Flash map
// ==========================================================================
`define FSL_ADDR_W 24
`define FSL_DATA_W 16
`define FSL_SEC_ADDR 24'h00_7FF7
`define FSL_KEY_ADDR0 24'h00_7FFC
`define FSL_KEY_WORDS 4
`define FSL_ERASED_WORD 16'hFFFF

// ==========================================================================
// Security word fields
// ==========================================================================
`define FSL_SEC_ON_BIT 1
`define FSL_SEC_OFF_BIT 0

// ==========================================================================
// Recovery erase
// ==========================================================================
`define FSL_DIV_W 7
`define FSL_ERASE_TICKS 1024
`define FSL_TICK_W 16

`endif

// *** logic/fsl_pkg.sv ***
// Types shared by the flash security interlock modules.
package fsl_pkg;

	// Boot load, normal running and recovery erase phases.
	typedef enum logic [2:0]
	{
		FSL_SEC_REQ,
		FSL_SEC_WAIT,
		FSL_KEY_REQ,
		FSL_KEY_WAIT,
		FSL_RUN,
		FSL_ERASE
	} fsl_state_type;

endpackage

// *** logic/fsl_erase_if.sv ***
// Handshake between the interlock and its recovery erase timer.
`include "fsl_defines.svh"

interface fsl_erase_if;
	logic start;
	logic abort;
	logic [`FSL_DIV_W-1:0] div;
	logic tick;
	logic busy;
	logic done;

	modport ctrl
	(
		output start,
		output abort,
		output div,
		input tick,
		input busy,
		input done
	);

	modport timer
	(
		input start,
		input abort,
		input div,
		output tick,
		output busy,
		output done
	);
endinterface

// *** logic/fsl_erase_timer.sv ***
// Erase clock divider and erase length counter for lockout recovery.
`include "fsl_defines.svh"

module fsl_erase_timer #(
	parameter int ERASE_TICKS = `FSL_ERASE_TICKS
)
(
	input wire logic clk,
	input wire logic rst_n,
	fsl_erase_if.timer erase
);

	// ======================================================================
	// Divider and tick counter
	// ======================================================================
	logic [`FSL_DIV_W-1:0] div_cnt;
	logic [`FSL_TICK_W-1:0] tick_cnt;
	wire div_wrap = (div_cnt == erase.div);
	wire last_tick = (tick_cnt == `FSL_TICK_W'(ERASE_TICKS - 1));

	// The erase clock runs at clk divided by div plus one, as one pulse.
	always_ff @(posedge clk)
	begin
		if (!rst_n || erase.start || !erase.busy || div_wrap)
			div_cnt <= '0;
		else
			div_cnt <= div_cnt + 1'b1;
	end

	// A dropped idle state aborts; the flash is then only partly erased.
	always_ff @(posedge clk)
	begin
		if (!rst_n || erase.abort)
		begin
			erase.busy <= 1'b0;
			erase.done <= 1'b0;
			erase.tick <= 1'b0;
			tick_cnt <= '0;
		end
		else if (erase.start)
		begin
			erase.busy <= 1'b1;
			erase.done <= 1'b0;
			erase.tick <= 1'b0;
			tick_cnt <= '0;
		end
		else
		begin
			erase.tick <= erase.busy && div_wrap;
			erase.done <= erase.busy && div_wrap && last_tick;
			if (erase.busy && div_wrap)
			begin
				tick_cnt <= tick_cnt + 1'b1;
				erase.busy <= !last_tick;
			end
		end
	end

endmodule

// *** logic/fsl_security_lockout.sv ***
// Flash security interlock: secure state, debug blocking and recovery.
`include "fsl_defines.svh"

// What this block does
// [R01] Secured when security word bit 1 is one and bit 0 is zero.
// [R02] Security state reloads from the stored word after every reset.
// [R03] Secured device disables core debug; normal execution continues.
// [R04] Boundary scan and identification stay reachable, secured or not.
// [R05] Secured device refuses every flash access from the debug port.
// [R06] Flash blocking holds from reset release, before startup code runs.
// [R07] Recovery erases all flash and clears protection when done.
// [R08] Host loads the public recovery instruction into the TAP first.
// [R09] Host then shifts a 7-bit erase clock divider value.
// [R10] Erase starts on Run-Test/Idle; host holds idle until finished.
// [R11] Host resets TAP and device after recovery to run unsecured.
// [R12] Zero programmed into security word unsecures after reset.
// [R13] Programming only clears bits; ones return only by erase.
// [R14] Matching four-word key unsecures at once and opens debug access.
// [R15] Key words must come as four back-to-back flash accesses.
// [R16] Key unlock lasts until the next reset only.
module fsl_security_lockout #(
	parameter int ERASE_TICKS = `FSL_ERASE_TICKS
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tap_recovery_sel,
	input wire logic tap_div_update,
	input wire logic [`FSL_DIV_W-1:0] tap_div,
	input wire logic tap_run_idle,
	input wire logic dbg_flash_req,
	input wire logic cpu_flash_acc,
	input wire logic cpu_key_wr,
	input wire logic [`FSL_DATA_W-1:0] cpu_key_data,
	input wire logic cpu_prog_req,
	input wire logic [`FSL_ADDR_W-1:0] cpu_prog_addr,
	input wire logic [`FSL_DATA_W-1:0] cpu_prog_data,
	input wire logic flash_rd_valid,
	input wire logic [`FSL_DATA_W-1:0] flash_rd_data,
	output logic secured,
	output logic debug_enable,
	output logic bscan_enable,
	output logic dbg_flash_grant,
	output logic dbg_flash_deny,
	output logic flash_rd_req,
	output logic [`FSL_ADDR_W-1:0] flash_rd_addr,
	output logic flash_prog_req,
	output logic [`FSL_ADDR_W-1:0] flash_prog_addr,
	output logic [`FSL_DATA_W-1:0] flash_prog_data,
	output logic flash_erase_active,
	output logic flash_erase_tick,
	output logic recovery_done
);

	// ======================================================================
	// TAP-side inputs come from another clock and pass two flip-flops
	// ======================================================================
	localparam int SW = `FSL_DIV_W + 3;
	logic [SW-1:0] tap_meta;
	logic [SW-1:0] tap_sync;
	logic div_upd_prev;

	always_ff @(posedge clk)
	begin
		tap_meta <= {tap_div, tap_div_update, tap_run_idle, tap_recovery_sel};
		tap_sync <= tap_meta;
		div_upd_prev <= rst_n && tap_sync[2];
	end

	wire rec_sel = tap_sync[0];
	wire run_idle = tap_sync[1];
	wire div_upd_rise = tap_sync[2] && !div_upd_prev;
	wire [`FSL_DIV_W-1:0] div_sync = tap_sync[SW-1:3];

	// ======================================================================
	// Boot load, run and erase sequencing
	// ======================================================================
	fsl_pkg::fsl_state_type state;
	fsl_pkg::fsl_state_type next_state;
	logic [1:0] load_pos;
	logic [`FSL_DATA_W-1:0] sec_word;
	logic [`FSL_DATA_W-1:0] key_word [`FSL_KEY_WORDS];
	logic div_loaded;
	logic [`FSL_DIV_W-1:0] div_value;
	logic idle_prev;
	fsl_erase_if erase_bus ();

	wire sec_bits_on = flash_rd_data[`FSL_SEC_ON_BIT] &&
		!flash_rd_data[`FSL_SEC_OFF_BIT];
	wire rd_ok = flash_rd_valid;
	wire erase_go = (state == fsl_pkg::FSL_RUN) && rec_sel && div_loaded &&
		run_idle && !idle_prev;
	wire erase_drop = (state == fsl_pkg::FSL_ERASE) && !run_idle;

	// Next state: security word first, then the key words, then run.
	always_comb
	begin
		next_state = state;
		case (state)
			fsl_pkg::FSL_SEC_REQ: next_state = fsl_pkg::FSL_SEC_WAIT;
			fsl_pkg::FSL_SEC_WAIT:
				if (rd_ok)
					next_state = fsl_pkg::FSL_KEY_REQ;
			fsl_pkg::FSL_KEY_REQ: next_state = fsl_pkg::FSL_KEY_WAIT;
			fsl_pkg::FSL_KEY_WAIT:
				if (rd_ok)
					next_state = (load_pos == 2'd3) ? fsl_pkg::FSL_RUN :
						fsl_pkg::FSL_KEY_REQ;
			fsl_pkg::FSL_RUN:
				if (erase_go)
					next_state = fsl_pkg::FSL_ERASE; // see [R10]
			fsl_pkg::FSL_ERASE:
				if (erase_bus.done || erase_drop)
					next_state = fsl_pkg::FSL_RUN;
			default: next_state = fsl_pkg::FSL_SEC_REQ;
		endcase
	end

	// Every reset restarts the load from the stored word.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			state <= fsl_pkg::FSL_SEC_REQ; // see [R02]
		else
			state <= next_state;
	end

	// Reads of the security word and key words during boot.
	always_ff @(posedge clk)
	begin
		flash_rd_req <= rst_n && (state == fsl_pkg::FSL_SEC_REQ ||
			state == fsl_pkg::FSL_KEY_REQ);
		if (!rst_n)
			flash_rd_addr <= `FSL_SEC_ADDR;
		else if (state == fsl_pkg::FSL_KEY_REQ)
			flash_rd_addr <= `FSL_KEY_ADDR0 + `FSL_ADDR_W'(load_pos);
		else if (state == fsl_pkg::FSL_SEC_REQ)
			flash_rd_addr <= `FSL_SEC_ADDR;
	end

	// Key word storage and load position.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			load_pos <= 2'd0;
		else if (state == fsl_pkg::FSL_KEY_WAIT && rd_ok)
		begin
			key_word[load_pos] <= flash_rd_data;
			load_pos <= load_pos + 2'd1;
		end
	end

	// ======================================================================
	// Erase divider capture and the erase timer
	// ======================================================================
	always_ff @(posedge clk)
	begin
		idle_prev <= rst_n && run_idle;
		if (!rst_n)
		begin
			div_loaded <= 1'b0;
			div_value <= '0;
		end
		else if (rec_sel && div_upd_rise)
		begin
			div_loaded <= 1'b1; // see [R09]
			div_value <= div_sync;
		end
		else if (!rec_sel)
			div_loaded <= 1'b0;
	end

	assign erase_bus.start = erase_go;
	assign erase_bus.abort = erase_drop; // see [R10]
	assign erase_bus.div = div_value;

	fsl_erase_timer #(
		.ERASE_TICKS(ERASE_TICKS)
	) u_erase_timer (
		.clk(clk),
		.rst_n(rst_n),
		.erase(erase_bus)
	);

	// ======================================================================
	// Back-door key matching
	// ======================================================================
	logic [1:0] key_pos;
	logic [`FSL_KEY_WORDS-1:0] key_match;

	genvar gi;
	generate
		for (gi = 0; gi < `FSL_KEY_WORDS; gi++)
		begin : g_key
			assign key_match[gi] = (key_word[gi] == cpu_key_data);
		end
	endgenerate

	wire key_running = (state == fsl_pkg::FSL_RUN);
	wire key_hit = key_running && cpu_key_wr && key_match[key_pos];
	wire key_unlock = key_hit && (key_pos == 2'd3);
	wire key_break = cpu_flash_acc || (cpu_key_wr && !key_hit);

	// Any other flash access or a wrong word restarts the sequence.
	always_ff @(posedge clk)
	begin
		if (!rst_n || key_break)
			key_pos <= 2'd0; // see [R15]
		else if (key_hit)
			key_pos <= key_pos + 2'd1;
	end

	// ======================================================================
	// Security state and the word shadow
	// ======================================================================
	wire sec_prog = key_running && cpu_prog_req &&
		(cpu_prog_addr == `FSL_SEC_ADDR);

	// Secured from reset release until the security word loads; after that only a matching key
	// or a finished erase clears it, and a new security word takes effect at the next reset.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			secured <= 1'b1; // see [R06] [R16]
		else if (state == fsl_pkg::FSL_SEC_WAIT && rd_ok)
			secured <= sec_bits_on; // see [R01] [R12]
		else if (erase_bus.done || key_unlock)
			secured <= 1'b0; // see [R07] [R14]
	end

	// The shadow follows programming, which can only clear bits.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			sec_word <= `FSL_ERASED_WORD;
		else if (state == fsl_pkg::FSL_SEC_WAIT && rd_ok)
			sec_word <= flash_rd_data;
		else if (erase_bus.done)
			sec_word <= `FSL_ERASED_WORD; // see [R07]
		else if (sec_prog)
			sec_word <= sec_word & cpu_prog_data; // see [R13]
	end

	// ======================================================================
	// Outputs toward the flash, the debug port and the TAP
	// ======================================================================
	wire [`FSL_DATA_W-1:0] prog_value = sec_prog ?
		(sec_word & cpu_prog_data) : cpu_prog_data;

	always_ff @(posedge clk)
	begin
		flash_prog_req <= rst_n && key_running && cpu_prog_req;
		flash_prog_addr <= rst_n ? cpu_prog_addr : '0;
		flash_prog_data <= rst_n ? prog_value : '0; // see [R13]
	end

	// Debug requests get a one-cycle answer; secured ones are refused.
	always_ff @(posedge clk)
	begin
		debug_enable <= rst_n && !secured; // see [R03]
		bscan_enable <= 1'b1; // see [R04]
		dbg_flash_grant <= rst_n && dbg_flash_req && !secured;
		dbg_flash_deny <= rst_n && dbg_flash_req && secured; // see [R05]
		flash_erase_active <= rst_n && erase_bus.busy; // see [R07]
		flash_erase_tick <= rst_n && erase_bus.tick;
	end

	// Completion stays visible until the host resets the device.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			recovery_done <= 1'b0;
		else if (erase_bus.done)
			recovery_done <= 1'b1; // see [R11]
	end

	// ======================================================================
	// Checks
	// ======================================================================
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_decode_word: assert property ( // see [R01]
		state == fsl_pkg::FSL_SEC_WAIT && rd_ok && !key_unlock
		|=> secured == $past(sec_bits_on))
		else $error("security decode wrong");
	a_boot_secured: assert property ( // see [R02]
		$rose(rst_n) |-> secured && state == fsl_pkg::FSL_SEC_REQ)
		else $error("reset did not secure");
	a_debug_follow: assert property ( // see [R03]
		##1 debug_enable == !$past(secured))
		else $error("debug enable does not track security");
	a_scan_always: assert property ( // see [R04]
		##1 bscan_enable)
		else $error("boundary scan disabled");
	a_debug_refused: assert property ( // see [R05]
		dbg_flash_req && secured |=> dbg_flash_deny && !dbg_flash_grant)
		else $error("secured debug access granted");
	a_lock_at_boot: assert property ( // see [R06]
		state inside {fsl_pkg::FSL_SEC_REQ, fsl_pkg::FSL_SEC_WAIT}
		|-> secured)
		else $error("unsecured before word loaded");
	a_erase_clears: assert property ( // see [R07]
		erase_bus.done |=> !secured && recovery_done ##1 !flash_erase_active)
		else $error("erase did not clear security");
	a_erase_starts: assert property ( // see [R10]
		erase_go |=> ##1 flash_erase_active)
		else $error("erase did not start");
	a_prog_mask: assert property ( // see [R13]
		sec_prog |=> flash_prog_req &&
		(flash_prog_data & ~$past(sec_word)) == '0)
		else $error("programming raised a bit");
	a_key_opens: assert property ( // see [R14]
		key_unlock |=> !secured ##1 debug_enable)
		else $error("key match did not unsecure");
	a_key_restart: assert property ( // see [R15]
		key_break |=> key_pos == 2'd0)
		else $error("key sequence not restarted");

	c_erase_done: cover property (erase_bus.done);
	c_key_unlock: cover property (key_unlock);
	c_debug_grant: cover property (dbg_flash_grant);
	c_boot_unsecured: cover property (
		state == fsl_pkg::FSL_RUN && !secured);

endmodule

// *** dv/fsl_flash_model.sv ***
// Behavioural flash array facing the interlock's boot read port.
`include "fsl_defines.svh"

module fsl_flash_model
(
	input wire logic clk,
	input wire logic slow,
	input wire logic rd_req,
	input wire logic [`FSL_ADDR_W-1:0] rd_addr,
	output logic rd_valid,
	output logic [`FSL_DATA_W-1:0] rd_data,
	input wire logic prog_req,
	input wire logic [`FSL_ADDR_W-1:0] prog_addr,
	input wire logic [`FSL_DATA_W-1:0] prog_data,
	input wire logic recovery_done
);
	timeunit 1ns;
	timeprecision 1ps;
	// Erased from time zero, before any initial block writes a word.
	logic [`FSL_DATA_W-1:0] mem [0:15] = '{default: 16'hFFFF};
	logic [3:0] idx;
	logic pend;
	logic done_q;
	int wait_n;

	// Idle read port; only the low address nibble is decoded.
	initial
	begin
		rd_valid = 1'b0;
		rd_data = 16'h0000;
		pend = 1'b0;
		done_q = 1'b0;
		wait_n = 0;
	end

	// Read answer, programming and mass erase.
	// Outside a valid cycle the data bus toggles so a stale word never
	// passes for a fresh one.
	always @(posedge clk)
	begin
		rd_valid <= 1'b0;
		rd_data <= ~rd_data;
		if (rd_req)
		begin
			pend <= 1'b1;
			idx <= rd_addr[3:0];
			wait_n <= slow ? 3 : 0;
		end
		else if (pend && wait_n > 0)
			wait_n <= wait_n - 1;
		else if (pend)
		begin
			rd_valid <= 1'b1;
			rd_data <= mem[idx];
			pend <= 1'b0;
		end
		if (prog_req)
			mem[prog_addr[3:0]] <= mem[prog_addr[3:0]] & prog_data;
		done_q <= recovery_done;
		if (recovery_done && !done_q)
			foreach (mem[i])
				mem[i] <= 16'hFFFF;
	end
endmodule

// *** dv/tb_flash_security_lockout.sv ***
// Testbench of the flash security interlock with a flash model.
`include "fsl_defines.svh"

module tb_flash_security_lockout;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int ET = 4;
	logic clk = 1'b0;
	logic rst_n, sel, upd, idle, dreq, facc, kwr, preq, rv, slow;
	logic [`FSL_DIV_W-1:0] div;
	logic [15:0] kd, pd, rd, fpd;
	logic [23:0] pa, ra, fpa, exp_ra;
	logic sec, dbe, bse, gnt, dny, rq, pr, ea, et, rdn;
	int errors, check_count, nrq;
	logic [15:0] codes [6] = '{16'h0000, 16'h0001, 16'h0002,
		16'h0003, 16'hFFFF, 16'hFFFE};

	fsl_security_lockout #(.ERASE_TICKS(ET)) DUT
	(
		.clk(clk), .rst_n(rst_n), .tap_recovery_sel(sel),
		.tap_div_update(upd), .tap_div(div), .tap_run_idle(idle),
		.dbg_flash_req(dreq), .cpu_flash_acc(facc), .cpu_key_wr(kwr),
		.cpu_key_data(kd), .cpu_prog_req(preq), .cpu_prog_addr(pa),
		.cpu_prog_data(pd), .flash_rd_valid(rv), .flash_rd_data(rd),
		.secured(sec), .debug_enable(dbe), .bscan_enable(bse),
		.dbg_flash_grant(gnt), .dbg_flash_deny(dny), .flash_rd_req(rq),
		.flash_rd_addr(ra), .flash_prog_req(pr), .flash_prog_addr(fpa),
		.flash_prog_data(fpd), .flash_erase_active(ea),
		.flash_erase_tick(et), .recovery_done(rdn)
	);

	fsl_flash_model flash
	(
		.clk(clk), .slow(slow), .rd_req(rq), .rd_addr(ra),
		.rd_valid(rv), .rd_data(rd), .prog_req(pr), .prog_addr(fpa),
		.prog_data(fpd), .recovery_done(rdn)
	);

	// Clock and read request counter used to see the boot load end.
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Boot reads ask for the security word first, then the keys in order.
	always @(posedge clk)
		if (rq === 1'b1)
		begin
			exp_ra = (nrq == 0) ? `FSL_SEC_ADDR :
				`FSL_KEY_ADDR0 + 24'(nrq - 1);
			chk("boot read addr", ra, exp_ra);
			nrq++;
		end

	task automatic chk(string s, logic [23:0] seen, logic [23:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", s, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic cyc(int k);
		repeat (k) @(negedge clk);
	endtask

	task automatic tmo();
		errors++;
		$display("[ERR] wait expected done seen timeout");
		wrap_up();
	endtask

	// One debug access; the answer stands for exactly one cycle.
	task automatic probe(logic g);
		dreq = 1'b1;
		cyc(1);
		dreq = 1'b0;
		chk("grant", gnt, g);
		chk("deny", dny, !g);
		cyc(1);
		chk("grant stands", gnt, 0);
		chk("deny stands", dny, 0);
	endtask

	// Reset with a given security word and wait for the five boot reads.
	task automatic boot(logic [15:0] w, logic early);
		int i;
		rst_n = 1'b0;
		flash.mem[7] = w;
		cyc(3);
		chk("secured in reset", sec, 1);
		nrq = 0;
		rst_n = 1'b1;
		if (early)
			probe(1'b0);
		for (i = 0; i < 100 && nrq < 5; i++)
			cyc(1);
		if (nrq < 5)
			tmo();
		cyc(8);
	endtask

	task automatic key_wr(logic [15:0] d);
		kwr = 1'b1;
		kd = d;
		cyc(1);
		kwr = 1'b0;
		cyc(1);
	endtask

	task automatic prog(logic [15:0] d, logic [15:0] exp);
		preq = 1'b1;
		pa = `FSL_SEC_ADDR;
		pd = d;
		cyc(1);
		chk("prog req", pr, 1);
		chk("prog addr", fpa, `FSL_SEC_ADDR);
		chk("prog data", fpd, exp);
		preq = 1'b0;
		cyc(1);
		chk("prog req ends", pr, 0);
	endtask

	// Every security word encoding, each after its own reset.
	task automatic t_codes();
		logic s;
		foreach (codes[i])
		begin
			boot(codes[i], i == 0);
			s = codes[i][1] & ~codes[i][0];
			chk("secured", sec, s);
			chk("debug enable", dbe, !s);
			chk("boundary scan", bse, 1);
			probe(!s);
		end
		$display("done codes");
	endtask

	// Broken and whole key sequences, then loss of the unlock at reset.
	task automatic t_key();
		logic [15:0] k [4] = '{16'h1234, 16'hA5C3, 16'h0F0F, 16'h7E81};
		foreach (k[i])
			flash.mem[12 + i] = k[i];
		slow = 1'b1;
		boot(16'h0002, 1'b0);
		key_wr(k[0]);
		key_wr(k[1]);
		facc = 1'b1;
		cyc(1);
		facc = 1'b0;
		key_wr(k[2]);
		key_wr(k[3]);
		chk("secured after split key", sec, 1);
		foreach (k[i])
			key_wr(k[i]);
		chk("secured after key", sec, 0);
		cyc(2);
		chk("debug after key", dbe, 1);
		probe(1'b1);
		boot(16'h0002, 1'b0);
		chk("secured after reset", sec, 1);
		slow = 1'b0;
		$display("done key");
	endtask

	// Clearing the security word, effective only from the next reset.
	task automatic t_prog();
		boot(16'h0002, 1'b0);
		prog(16'h0000, 16'h0000);
		chk("secured before reset", sec, 1);
		boot(flash.mem[7], 1'b0);
		chk("secured after reset", sec, 0);
		prog(16'h0002, 16'h0000);
		$display("done prog");
	endtask

	task automatic wait_ea();
		int i;
		for (i = 0; i < 20 && ea !== 1'b1; i++)
			cyc(1);
		if (ea !== 1'b1)
			tmo();
	endtask

	// No erase without the recovery instruction; then an aborted erase
	// and a full one with divider 2.
	task automatic t_recov();
		int n, m, i;
		boot(16'h0002, 1'b0);
		idle = 1'b1;
		cyc(8);
		chk("erase without instruction", ea, 0);
		idle = 1'b0;
		cyc(3);
		sel = 1'b1;
		div = 7'h02;
		cyc(3);
		upd = 1'b1;
		cyc(3);
		upd = 1'b0;
		cyc(3);
		idle = 1'b1;
		wait_ea();
		cyc(3);
		idle = 1'b0;
		cyc(6);
		chk("erase aborted", ea, 0);
		chk("secured after abort", sec, 1);
		chk("done after abort", rdn, 0);
		idle = 1'b1;
		wait_ea();
		n = 0;
		m = 0;
		for (i = 0; i < 200 && ea === 1'b1; i++)
		begin
			n++;
			m += int'(et === 1'b1);
			cyc(1);
		end
		// The last erase tick lands in the cycle in which active drops.
		m += int'(et === 1'b1);
		chk("erase cycles", n, ET * 3);
		chk("erase ticks", m, ET);
		cyc(1);
		chk("secured after erase", sec, 0);
		chk("recovery done", rdn, 1);
		idle = 1'b0;
		sel = 1'b0;
		boot(flash.mem[7], 1'b0);
		chk("secured after recovery", sec, 0);
		chk("done after reset", rdn, 0);
		$display("done recovery");
	endtask

	// Main sequence.
	initial
	begin
		{rst_n, sel, upd, idle, dreq, facc, kwr, preq, slow} = '0;
		div = 7'h00;
		kd = 16'h0000;
		pd = 16'h0000;
		pa = 24'h00_0000;
		t_codes();
		t_key();
		t_prog();
		t_recov();
		wrap_up();
	end
endmodule
